// ---- rtl/tss_slave.sv ----
// smbus slave, register file and alert logic of the thermal supervisor
// assumes scl/sda/strap pins are asynchronous and the host owns scl
`timescale 1ns/10ps
module tss_slave #(
  parameter int CONV_CYCLES = tss_pkg::CONV_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // address straps
  input  wire logic       addr2_or_remote_diode,
  input  wire logic       addr_sel1,
  input  wire logic       addr_sel0,
  input  wire logic       remote_diode_present,
  // analog front end
  input  wire logic [8:0] local_sample,
  input  wire logic [8:0] remote_sample,
  input  wire logic       diode_fault,
  // alert pin, open drain
  output logic            alert_out,
  output logic            alert_oe
);
  typedef struct packed {
    logic [1:0]          scl_s;
    logic [1:0]          sda_s;
    logic                scl_p;
    logic                sda_p;
    tss_pkg::tss_bus_st_t st;
    logic [7:0]          sh;
    logic [3:0]          bits;
    logic                rw;
    logic [1:0]          nbyte;
    logic [7:0]          ptr;
    logic [15:0]         txw;
    logic [7:0]          lo_hold;
    logic [2:0]          addr_lo;
    logic                strap_done;
    logic [8:0]          temp;
    logic [7:0]          cfg;
    logic [8:0]          hyst;
    logic [8:0]          setpt;
    logic [2:0]          qcnt;
    logic                over_seen;
    logic                want_over;
    logic                cmp_alert;
    logic                restart;
    logic                drive_low;
    logic                alert_oe;
  } tss_state_t;

  tss_state_t         s_q, s_d;
  tss_pkg::tss_conv_t conv;
  logic               scl_rise, scl_fall, start_c, stop_c;
  logic               hot, cold;

  // queue depth 1, 2, 4 or 6 conversions
  function automatic logic [2:0] fq_depth(input logic [1:0] code);
    case (code)
      2'h0:    fq_depth = 3'h1;
      2'h1:    fq_depth = 3'h2;
      2'h2:    fq_depth = 3'h4;
      default: fq_depth = 3'h6;
    endcase
  endfunction : fq_depth

  // read data for a pointer, left justified
  function automatic logic [15:0] rd_word(input tss_state_t s);
    case (s.ptr[1:0])
      tss_pkg::PTR_RESULT:   rd_word = {s.temp, 7'h00};
      tss_pkg::PTR_SETTINGS: rd_word = {s.cfg, 8'h00};
      tss_pkg::PTR_HYST:     rd_word = {s.hyst, 7'h00};
      default:               rd_word = {s.setpt, 7'h00};
    endcase
  endfunction : rd_word

  tss_converter #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_conv (
    .clk           (clk),
    .rst           (rst),
    .restart       (s_q.restart),
    .halt          (s_q.cfg[tss_pkg::B_HALT]),
    .remote        (s_q.cfg[tss_pkg::B_ZONE]),
    .local_sample  (local_sample),
    .remote_sample (remote_sample),
    .diode_fault   (diode_fault),
    .conv          (conv)
  );

  // edges only from the second synchroniser stage onward
  assign scl_rise = s_q.scl_s[1] && !s_q.scl_p;
  assign scl_fall = !s_q.scl_s[1] && s_q.scl_p;
  assign start_c  = s_q.scl_s[1] && s_q.scl_p && s_q.sda_p && !s_q.sda_s[1];
  assign stop_c   = s_q.scl_s[1] && s_q.scl_p && !s_q.sda_p && s_q.sda_s[1];
  assign hot  = $signed(conv.temp) > $signed(s_q.setpt);
  assign cold = $signed(conv.temp) < $signed(s_q.hyst);

  always_comb begin
    s_d = s_q;
    s_d.scl_s   = {s_q.scl_s[0], scl_in};
    s_d.sda_s   = {s_q.sda_s[0], sda_in};
    s_d.scl_p   = s_q.scl_s[1];
    s_d.sda_p   = s_q.sda_s[1];
    s_d.restart = 1'b0;
    // straps caught once, after reset release
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.addr_lo = {addr2_or_remote_diode && !remote_diode_present,
                     addr_sel1, addr_sel0};
    end
    if (start_c) begin
      s_d.st = tss_pkg::ST_ADDR;
      s_d.bits = '0;
      s_d.drive_low = 1'b0;
    end else if (stop_c) begin
      s_d.st = tss_pkg::ST_IDLE;
      s_d.drive_low = 1'b0;
    end else begin
      case (s_q.st)
        tss_pkg::ST_ADDR: begin
          if (scl_rise) begin
            s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
            s_d.bits = s_q.bits + 4'h1;
          end
          if (scl_fall && s_q.bits == 4'h8) begin
            if (s_q.sh[7:1] == {tss_pkg::ADDR_HI, s_q.addr_lo}) begin
              s_d.st = tss_pkg::ST_AACK;
              s_d.drive_low = 1'b1;
              s_d.rw = s_q.sh[0];
              s_d.nbyte = '0;
              s_d.txw = rd_word(s_q);
            end else begin
              s_d.st = tss_pkg::ST_IDLE;
            end
          end
        end
        tss_pkg::ST_AACK, tss_pkg::ST_WACK: begin
          if (scl_fall) begin
            s_d.bits = '0;
            if (s_q.rw) begin
              s_d.st = tss_pkg::ST_RTX;
              s_d.drive_low = !s_q.txw[15];
              s_d.txw = {s_q.txw[14:0], 1'b0};
            end else begin
              s_d.st = tss_pkg::ST_WRX;
              s_d.drive_low = 1'b0;
            end
          end
        end
        tss_pkg::ST_WRX: begin
          if (scl_rise) begin
            s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
            s_d.bits = s_q.bits + 4'h1;
          end
          if (scl_fall && s_q.bits == 4'h8) begin
            s_d.st = tss_pkg::ST_WACK;
            s_d.drive_low = 1'b1;
            s_d.nbyte = s_q.nbyte + 2'h1;
            if (s_q.nbyte == 2'h0) begin
              s_d.ptr = s_q.sh;
            end else if (s_q.nbyte == 2'h1) begin
              s_d.lo_hold = s_q.sh;
              if (s_q.ptr[1:0] == tss_pkg::PTR_SETTINGS) begin
                s_d.cfg = {s_q.cfg[tss_pkg::B_STS], s_q.sh[6:0]};
                if (s_q.sh[tss_pkg::B_ZONE] && !s_q.cfg[tss_pkg::B_ZONE]) begin
                  s_d.restart = 1'b1;
                end
                // mode cleared from interrupt: rearm for overtemperature;
                // plain comparator writes must not lose a pending release
                if (!s_q.sh[tss_pkg::B_MODE] && s_q.cfg[tss_pkg::B_MODE]) begin
                  s_d.want_over = 1'b1;
                end
                // halt in interrupt mode drops the latched status
                if (s_q.sh[tss_pkg::B_HALT] && s_q.cfg[tss_pkg::B_MODE]) begin
                  s_d.cfg[tss_pkg::B_STS] = 1'b0;
                end
              end
            end else if (s_q.nbyte == 2'h2) begin
              // ptr 0 and reserved values are acked but not stored
              if (s_q.ptr == {6'h00, tss_pkg::PTR_HYST}) begin
                s_d.hyst = {s_q.lo_hold, s_q.sh[7]};
              end else if (s_q.ptr == {6'h00, tss_pkg::PTR_SETPOINT}) begin
                s_d.setpt = {s_q.lo_hold, s_q.sh[7]};
              end
            end
          end
        end
        tss_pkg::ST_RTX: begin
          if (scl_rise) begin
            s_d.bits = s_q.bits + 4'h1;
          end
          if (scl_fall) begin
            if (s_q.bits == 4'h8) begin
              s_d.st = tss_pkg::ST_RACK;
              s_d.drive_low = 1'b0;
            end else begin
              s_d.drive_low = !s_q.txw[15];
              s_d.txw = {s_q.txw[14:0], 1'b0};
            end
          end
        end
        tss_pkg::ST_RACK: begin
          if (scl_rise) begin
            // any completed read byte clears latched status
            if (s_q.cfg[tss_pkg::B_MODE]) begin
              s_d.cfg[tss_pkg::B_STS] = 1'b0;
            end
            s_d.st = s_q.sda_s[1] ? tss_pkg::ST_IDLE : tss_pkg::ST_AACK;
          end
        end
        default: s_d.st = tss_pkg::ST_IDLE;
      endcase
    end

    // event detection with fault queue
    if (conv.valid && !s_q.cfg[tss_pkg::B_HALT]) begin
      if ((hot && s_q.want_over) || (cold && !s_q.want_over)) begin
        if (s_q.qcnt + 3'h1 >= fq_depth(s_q.cfg[tss_pkg::B_FQ +: 2])) begin
          s_d.qcnt = '0;
          s_d.want_over = !s_q.want_over;
          s_d.cmp_alert = s_q.want_over;
          if (s_q.cfg[tss_pkg::B_MODE]) begin
            s_d.cfg[tss_pkg::B_STS] = 1'b1;
          end
        end else begin
          s_d.qcnt = s_q.qcnt + 3'h1;
        end
      end else begin
        s_d.qcnt = '0;
      end
      s_d.temp = conv.temp;
    end
    if (!s_q.cfg[tss_pkg::B_MODE]) begin
      s_d.cfg[tss_pkg::B_STS] = s_d.cmp_alert;
    end
    // active pin level vs polarity; mask blocks any pull-down
    s_d.alert_oe = !s_d.cfg[tss_pkg::B_MASK] &&
                   (s_d.cfg[tss_pkg::B_STS] == !s_d.cfg[tss_pkg::B_POL]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.scl_s <= 2'h3;
      s_q.sda_s <= 2'h3;
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.st <= tss_pkg::ST_IDLE;
      s_q.ptr <= {6'h00, tss_pkg::PTR_RESULT};
      s_q.cfg <= tss_pkg::SETTINGS_RST;
      s_q.hyst <= tss_pkg::HYST_RESET;
      s_q.setpt <= tss_pkg::SETPT_RESET;
      s_q.want_over <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_out   = 1'b0;
  assign sda_oe    = s_q.drive_low;
  assign alert_out = 1'b0;
  assign alert_oe  = s_q.alert_oe;
endmodule : tss_slave

// ---- rtl/tss_pkg.sv ----
// package for the thermal supervisor smbus slave: types and constants
// assumes one 250 MHz clock; pins are sampled inside the slave
//
// Contract
// - slave address is 1001 followed by three strapped pin bits, 48h-4Fh.
// - acknowledge and respond only when the address byte matches our own.
// - a diode on the shared pin reads as address bit two equal zero.
// - polarity bit picks alert sense; mode bit picks comparator or interrupt.
// - while alert mask is set the alert pin is never pulled low.
// - event when result exceeds setpoint or falls below hysteresis.
// - temperatures are 9-bit two's complement; compares are signed.
// - sensor select bit: zero internal, one remote; resets to zero.
// - writing config to remote restarts conversion, then updates status.
// - remote diode fault forces full-scale reading 0 1111 1111.
// - faults are reported only after the debounce count of conversions.
// - write byte and write word: address, command byte, data bytes.
// - read: address, command, repeated start, address read, then data.
// - pointer-reuse read returns one or two bytes from last pointer.
// - each command byte latches into the write-only pointer; it persists.
// - pointer 0..3 selects result, config, hysteresis, setpoint.
// - config is one byte wide, byte transactions only.
// - result and thresholds are 9 bits left-justified in 16-bit words.
// - device only pulls data low or releases it.
// - temperature lsb is 0.5 degrees, left-justified, low seven bits zero.
// - comparator mode: alert holds until below hysteresis for debounce.
// - interrupt mode: status clears on any register read or shutdown.
// - reset setpoint is +80 degrees, hysteresis +75 degrees.
package tss_pkg;
  localparam logic [3:0] ADDR_HI      = 4'h9;
  localparam logic [1:0] PTR_RESULT   = 2'h0;
  localparam logic [1:0] PTR_SETTINGS = 2'h1;
  localparam logic [1:0] PTR_HYST     = 2'h2;
  localparam logic [1:0] PTR_SETPOINT = 2'h3;
  localparam logic [8:0] HYST_RESET   = 9'h096;
  localparam logic [8:0] SETPT_RESET  = 9'h0a0;
  localparam logic [8:0] FULL_SCALE   = 9'h0ff;
  localparam logic [7:0] SETTINGS_RST = 8'h00;
  // settings register bit positions
  localparam int B_HALT  = 0;
  localparam int B_MODE  = 1;
  localparam int B_POL   = 2;
  localparam int B_FQ    = 3;
  localparam int B_ZONE  = 5;
  localparam int B_MASK  = 6;
  localparam int B_STS   = 7;
  // conversion time, in microseconds, of one internal conversion
  localparam int CONV_US     = 100;
  localparam int CLK_MHZ     = 250;
  localparam int CONV_CYCLES = CONV_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_WRX  = 3'b010,
    ST_WACK = 3'b110,
    ST_RTX  = 3'b111,
    ST_RACK = 3'b101
  } tss_bus_st_t;

  typedef struct packed {
    logic       sda_oe;
    logic       alert_oe;
  } tss_pins_t;

  typedef struct packed {
    logic [8:0] temp;
    logic       valid;
    logic       fault;
  } tss_conv_t;
endpackage : tss_pkg

// ---- rtl/tss_converter.sv ----
// conversion sequencer: paces results and applies the diode fault override
// assumes adc samples arrive as levels from the analog front end, same clock
`timescale 1ns/10ps
module tss_converter #(
  parameter int CONV_CYCLES = tss_pkg::CONV_CYCLES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // control
  input  wire logic              restart,
  input  wire logic              halt,
  input  wire logic              remote,
  // analog front end
  input  wire logic [8:0]        local_sample,
  input  wire logic [8:0]        remote_sample,
  input  wire logic              diode_fault,
  // result
  output tss_pkg::tss_conv_t     conv
);
  typedef struct packed {
    logic [31:0]        cnt;
    tss_pkg::tss_conv_t out;
  } tss_cv_state_t;

  tss_cv_state_t s_q, s_d;
  logic [31:0]   span;

  // remote conversions take twice as long for input settling
  always_comb begin
    span = remote ? 32'(CONV_CYCLES * 2) : 32'(CONV_CYCLES);
    s_d = s_q;
    s_d.out.valid = 1'b0;
    if (restart || halt) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= span - 32'h1) begin
      s_d.cnt = '0;
      s_d.out.valid = 1'b1;
      s_d.out.fault = remote && diode_fault;
      if (remote && diode_fault) begin
        s_d.out.temp = tss_pkg::FULL_SCALE;
      end else begin
        s_d.out.temp = remote ? remote_sample : local_sample;
      end
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign conv = s_q.out;
endmodule : tss_converter

// ---- dv/tss_slave_assertions.sv ----
// pin-level checks for the smbus slave of the thermal supervisor
// assumes one clock domain and the async active-high rst of the slave
`timescale 1ns/10ps
module tss_slave_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic alert_out,
  input wire logic alert_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_released;
    !sda_oe && !alert_oe;
  endsequence
  sequence s_ack_hold;
    sda_oe [*6];
  endsequence
  sequence s_scl_idle;
    scl_in [*8];
  endsequence

  chk_reset_quiet: assert property (disable iff (1'b0) rst |-> s_released)
    else $error("pins pulled during reset");
  chk_release_idle: assert property ($fell(rst) |-> !sda_oe [*4])
    else $error("data pulled right after reset");
  chk_alert_quiet: assert property ($fell(rst) |-> !alert_oe [*8])
    else $error("alert pulled right after reset");
  chk_data_low: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data line driven high");
  chk_alert_drain: assert property (alert_oe |-> alert_out == 1'b0)
    else $error("alert line driven high");
  chk_change_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
    else $error("data pull changed while clock high");
  chk_stable_high: assert property ($rose(scl_in) |=> $stable(sda_oe) [*3])
    else $error("data pull moved in clock high phase");
  chk_ack_hold: assert property ($rose(sda_oe) |-> s_ack_hold)
    else $error("data pull shorter than a bit");
  chk_idle_free: assert property (s_scl_idle |-> !sda_oe)
    else $error("data pulled on an idle bus");
endmodule : tss_slave_assertions

bind tss_slave tss_slave_assertions i_chk (
  .clk      (clk),
  .rst      (rst),
  .scl_in   (scl_in),
  .sda_out  (sda_out),
  .sda_oe   (sda_oe),
  .alert_out(alert_out),
  .alert_oe (alert_oe)
);

// ---- dv/tss_host.sv ----
// smbus host model: owns the serial clock, pulls data low or releases it
// assumes the bench resolves data with a pull-up; 32 ns bit, clock idles high
`timescale 1ns/10ps
module tss_host (
  // bus pins
  output logic       scl,
  output logic       pull,
  input  wire logic  sda,
  // one pulse per ack slot or received byte
  output logic [7:0] res,
  output logic       res_vld
);
  initial begin
    scl     = 1'b1;
    pull    = 1'b0;
    res     = 8'h00;
    res_vld = 1'b0;
  end

  // long low phase: the slave lets go of its ack late after the fall
  task automatic bit_io(input logic b, output logic s);
    #4;
    pull = !b;
    #16;
    scl = 1'b1;
    #10;
    s = sda;
    #2;
    scl = 1'b0;
  endtask : bit_io

  task automatic start();
    pull = 1'b0;
    #24;
    scl = 1'b1;
    #16;
    pull = 1'b1;
    #16;
    scl = 1'b0;
  endtask : start

  task automatic stop();
    pull = 1'b1;
    #20;
    scl = 1'b1;
    #16;
    pull = 1'b0;
    #16;
  endtask : stop

  task automatic put(input logic [7:0] v);
    res     = v;
    res_vld = 1'b1;
    #1;
    res_vld = 1'b0;
  endtask : put

  task automatic wr(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    put({7'h00, !s});
  endtask : wr

  task automatic rd(input logic last);
    logic [7:0] b;
    logic       s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, s);
    put(b);
  endtask : rd

  // cmd below zero: no command byte, reads reuse the latched pointer
  task automatic op(input logic [6:0] a, input int cmd, input int nw,
                    input logic [15:0] d, input int nr);
    start();
    wr({a, cmd < 0 && nr > 0});
    if (cmd >= 0) wr(cmd[7:0]);
    for (int i = 0; i < nw; i++) wr(d[15-8*i -: 8]);
    if (nr > 0 && cmd >= 0) begin
      start();
      wr({a, 1'b1});
    end
    for (int i = 0; i < nr; i++) rd(i == nr - 1);
    stop();
  endtask : op
endmodule : tss_host

// ---- dv/thermal_supervisor_smbus_slave_test.sv ----
// self-checking bench of the thermal supervisor smbus slave
// assumes tss_host drives the bus; data line has a pull-up
`timescale 1ns/10ps
module thermal_supervisor_smbus_slave_test;
  typedef struct {logic [7:0] e; logic [7:0] m;} tss_note_t;
  logic        clk = 1'b0;
  logic        rst = 1'b0;
  logic        scl, pull, sda, sda_oe, sda_out, alert_out, alert_oe;
  logic        a2 = 1'b0, a1 = 1'b0, a0 = 1'b0, rdp = 1'b0, flt = 1'b0;
  logic [8:0]  loc = 9'h098, rem = 9'h032;
  logic [7:0]  res;
  logic        res_vld;
  logic [6:0]  own;
  logic [31:0] seed = 32'h00009029;
  logic [31:0] r;
  tss_note_t   q[$];
  tss_note_t   n;
  int          bad_count = 0, n_compared = 0;

  always #2 clk = ~clk;
  assign sda = !(pull || sda_oe);

  tss_host i_host (.scl(scl), .pull(pull), .sda(sda), .res(res),
                   .res_vld(res_vld));
  tss_slave #(.CONV_CYCLES(20)) i_dut (.clk(clk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr2_or_remote_diode(a2), .addr_sel1(a1), .addr_sel0(a0),
    .remote_diode_present(rdp), .local_sample(loc), .remote_sample(rem),
    .diode_fault(flt), .alert_out(alert_out), .alert_oe(alert_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input string s, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    check("pending notes", 8'(q.size()), 8'h00);
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // every ack slot and read byte of the host lands here in order
  always @(posedge res_vld) begin
    if (q.size() == 0) begin
      check("unexpected result", 8'h01, 8'h00);
    end else begin
      n = q.pop_front();
      check("bus byte", res & n.m, n.e & n.m);
    end
  end

  task automatic xfer(input logic [6:0] a, input int cmd, input int nw,
                      input logic [15:0] d, input int nr,
                      input logic [15:0] e, input logic [15:0] m);
    int nk;
    nk = (cmd >= 0) ? 2 + nw + (nr > 0) : 1;
    for (int i = 0; i < nk; i++) q.push_back('{{7'h00, a == own}, 8'hff});
    for (int i = 0; i < nr; i++) q.push_back('{e[15-8*i -: 8], m[15-8*i -: 8]});
    i_host.op(a, cmd, nw, d, nr);
    @(negedge clk);
  endtask : xfer

  // low seven bits of a word are left out of the compare, hence the ff80 mask
  task automatic rdw(input int p, input logic [8:0] v);
    xfer(own, p, 0, 16'h0000, 2, {v[8:1], v[0], 7'h00}, 16'hff80);
  endtask : rdw

  task automatic wrw(input int p, input logic [8:0] v);
    xfer(own, p, 2, {v[8:1], v[0], 7'h00}, 0, 16'h0000, 16'h0000);
  endtask : wrw

  task automatic wrb(input int p, input logic [7:0] v);
    xfer(own, p, 1, {v, 8'h00}, 0, 16'h0000, 16'h0000);
  endtask : wrb

  task automatic rdb(input int p, input logic [7:0] v, input logic [7:0] m);
    xfer(own, p, 0, 16'h0000, 1, {v, 8'h00}, {m, 8'h00});
  endtask : rdb

  task automatic alert(input logic x);
    repeat (300) @(negedge clk);
    check("alert pull", {7'h00, alert_oe}, {7'h00, x});
  endtask : alert

  task automatic do_reset();
    own = {tss_pkg::ADDR_HI, a2 & !rdp, a1, a0};
    // nonblocking so the reset edge is seen even at time zero
    rst <= 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (100) @(negedge clk);
  endtask : do_reset

  initial begin
    r = rnd();
    {a2, a1, a0} = r[2:0];
    loc = 9'h097 + {7'h00, r[4:3]};
    do_reset();
    rdw(-1, loc);
    xfer(own ^ 7'h04, -1, 0, 16'h0000, 0, 16'h0000, 16'h0000);
    rdw(2, 9'h096);
    rdw(3, 9'h0a0);
    rdb(1, 8'h00, 8'hff);
    wrw(0, 9'h1ff);
    rdw(-1, loc);
    $display("test defaults done");
    wrw(3, 9'h1b0);
    wrw(2, 9'h192);
    rdw(3, 9'h1b0);
    alert(1'b1);
    wrb(1, 8'h40);
    alert(1'b0);
    rdb(1, 8'h40, 8'h7f);
    wrb(1, 8'h04);
    alert(1'b0);
    wrw(3, 9'h0a0);
    wrw(2, 9'h096);
    wrb(1, 8'h04);
    alert(1'b0);
    loc = 9'h090;
    alert(1'b1);
    $display("test alert done");
    flt = 1'b1;
    wrb(1, 8'h20);
    repeat (300) @(negedge clk);
    rdw(0, 9'h0ff);
    alert(1'b1);
    flt = 1'b0;
    loc = 9'h0b0;
    wrb(1, 8'h02);
    alert(1'b1);
    rdb(1, 8'h82, 8'hff);
    alert(1'b0);
    $display("test fault and interrupt done");
    a2 = 1'b1;
    rdp = 1'b1;
    loc = 9'h098;
    do_reset();
    xfer(own | 7'h04, -1, 0, 16'h0000, 0, 16'h0000, 16'h0000);
    rdw(-1, 9'h098);
    $display("test strap done");
    end_of_test();
  end

  initial begin
    #300000;
    check("watchdog", 8'h01, 8'h00);
    end_of_test();
  end
endmodule : thermal_supervisor_smbus_slave_test
